// *** rtl/lcb_defs.vh ***
`ifndef LCB_DEFS_VH
`define LCB_DEFS_VH

// Register indices; the byte address is four times the index
`define LCB_IDX_MASTER_CONTROL 10'h000
`define LCB_IDX_MASTER_CONFIG 10'h001
`define LCB_IDX_POWER 10'h002
`define LCB_IDX_BATTERY_MONITOR 10'h003
`define LCB_IDX_CONTRAST 10'h004
`define LCB_IDX_TOGGLE_RATE 10'h005
`define LCB_IDX_SEGMENT_DATA 10'h006
`define LCB_IDX_STATUS 10'h007
`define LCB_IDX_BLINK_MASK 10'h09e

// Field positions
`define LCB_BIT_CTRL_REGULATOR 2
`define LCB_BIT_CFG_BYPASS 0
`define LCB_BIT_PWR_MONITOR 3
`define LCB_BIT_VBM_ENABLE 7
`define LCB_LSB_CTRL_MUX 0
`define LCB_MSB_CTRL_MUX 1

// Reset values
`define LCB_RST_MASTER_CONTROL 8'h00
`define LCB_RST_MASTER_CONFIG 8'h00
`define LCB_RST_POWER 8'h00
`define LCB_RST_BATTERY_MONITOR 8'h00
`define LCB_RST_CONTRAST 8'h00
`define LCB_RST_TOGGLE_RATE 8'h00
`define LCB_RST_SEGMENT_DATA 8'h00
`define LCB_RST_BLINK_MASK 8'h00

// Contrast: 1900 mV base, 60 mV per step, 3720 mV ceiling
`define LCB_CONTRAST_BASE_MV 1900
`define LCB_CONTRAST_STEP_MV 60
`define LCB_CONTRAST_TOP_MV 3720
`define LCB_CONTRAST_MAX_CODE 8'h1e

// Contrast control modes
`define LCB_MODE_INVALID 3'h0
`define LCB_MODE_BYPASS 3'h1
`define LCB_MODE_MINIMUM 3'h2
`define LCB_MODE_CONSTANT 3'h3
`define LCB_MODE_FOURTH 3'h4

// AXI responses
`define LCB_RESP_OKAY 2'h0
`define LCB_RESP_SLVERR 2'h2

`endif

// *** rtl/lcb_contrast_blink.v ***
// How it works
// - Contrast register sets target 1.9 V to 3.72 V in 60 mV steps.
// - Bypass mode bits 0,1,0,0 disable regulation; supply follows battery.
// - Minimum mode: battery feeds supply directly, charge pump on when battery low.
// - Constant mode: resistor regulates above threshold, charge pump below.
// - Control bits 1,0,0,1 select the fourth contrast mode.
// - Eight mask bits map to segment data zero bits; one means blinking.
// - Masked segments toggle at the toggle rate without software help.
// - Blinking segments limited to 2, 4, 6, 8 by multiplex mode.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "lcb_defs.vh"

module lcb_contrast_blink #(
    parameter ADDR_WIDTH = 12
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    output wire [1:0] s_axi_bresp_out,
    output wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output wire [31:0] s_axi_rdata_out,
    output wire [1:0] s_axi_rresp_out,
    output wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    input wire vbat_low_in,
    input wire frame_tick_in,
    output wire [7:0] segment_out,
    output wire [2:0] contrast_mode_out,
    output wire supply_bypass_out,
    output wire regulator_en_out,
    output wire charge_pump_en_out,
    output wire high_load_out,
    output wire [7:0] contrast_code_out
);

    reg awready_ff;
    reg wready_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg arready_ff;
    reg rvalid_ff;
    reg [1:0] rresp_ff;
    reg [31:0] rdata_ff;
    reg [9:0] waddr_ff;
    reg aw_got_ff;
    reg [7:0] wdata_ff;
    reg wstrb0_ff;
    reg w_got_ff;

    reg [7:0] master_control_ff;
    reg [7:0] master_config_ff;
    reg [7:0] power_ff;
    reg [7:0] battery_monitor_ff;
    reg [7:0] contrast_ff;
    reg [7:0] toggle_rate_ff;
    reg [7:0] segment_data_ff;
    reg [7:0] blink_mask_ff;

    reg vbat_meta_ff;
    reg vbat_sync_ff;
    reg frame_meta_ff;
    reg frame_sync_ff;
    reg frame_prev_ff;
    reg [7:0] frame_count_ff;
    reg blink_off_ff;
    reg [7:0] segment_ff;
    reg [2:0] mode_ff;
    reg bypass_ff;
    reg regulator_ff;
    reg pump_ff;
    reg high_load_ff;
    reg [7:0] code_ff;

    reg [2:0] nxt_mode;
    reg nxt_bypass;
    reg nxt_regulator;
    reg nxt_pump;
    reg [7:0] nxt_limit_mask;
    reg [7:0] nxt_segment;

    wire frame_edge;
    wire do_write;
    wire [9:0] raddr_idx;

    function is_mapped;
        input [9:0] idx;
        begin
            is_mapped = (idx <= `LCB_IDX_STATUS) || (idx == `LCB_IDX_BLINK_MASK);
        end
    endfunction

    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out = wready_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign segment_out = segment_ff;
    assign contrast_mode_out = mode_ff;
    assign supply_bypass_out = bypass_ff;
    assign regulator_en_out = regulator_ff;
    assign charge_pump_en_out = pump_ff;
    assign high_load_out = high_load_ff;
    assign contrast_code_out = code_ff;

    assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
    assign raddr_idx = s_axi_araddr_in[11:2];
    assign frame_edge = frame_sync_ff && !frame_prev_ff;

    // Write channel: address and data accepted in either order, one at a time
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= 10'h000;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `LCB_RESP_OKAY;
        end else begin
            awready_ff <= !aw_got_ff && !(awready_ff && s_axi_awvalid_in) && !bvalid_ff;
            wready_ff <= !w_got_ff && !(wready_ff && s_axi_wvalid_in) && !bvalid_ff;
            if (awready_ff && s_axi_awvalid_in) begin
                aw_got_ff <= 1'b1;
                waddr_ff <= s_axi_awaddr_in[11:2];
            end
            if (wready_ff && s_axi_wvalid_in) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata_in[7:0];
                wstrb0_ff <= s_axi_wstrb_in[0];
            end
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= is_mapped(waddr_ff) ? `LCB_RESP_OKAY : `LCB_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready_in) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Register file
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            master_control_ff <= `LCB_RST_MASTER_CONTROL;
            master_config_ff <= `LCB_RST_MASTER_CONFIG;
            power_ff <= `LCB_RST_POWER;
            battery_monitor_ff <= `LCB_RST_BATTERY_MONITOR;
            contrast_ff <= `LCB_RST_CONTRAST;
            toggle_rate_ff <= `LCB_RST_TOGGLE_RATE;
            segment_data_ff <= `LCB_RST_SEGMENT_DATA;
            blink_mask_ff <= `LCB_RST_BLINK_MASK;
        end else if (do_write && wstrb0_ff) begin
            case (waddr_ff)
                `LCB_IDX_MASTER_CONTROL: master_control_ff <= wdata_ff;
                `LCB_IDX_MASTER_CONFIG: master_config_ff <= wdata_ff;
                `LCB_IDX_POWER: power_ff <= wdata_ff;
                `LCB_IDX_BATTERY_MONITOR: battery_monitor_ff <= wdata_ff;
                `LCB_IDX_CONTRAST: contrast_ff <= wdata_ff;
                `LCB_IDX_TOGGLE_RATE: toggle_rate_ff <= wdata_ff;
                `LCB_IDX_SEGMENT_DATA: segment_data_ff <= wdata_ff;
                `LCB_IDX_BLINK_MASK: blink_mask_ff <= wdata_ff;
                default: begin
                end
            endcase
        end
    end

    // Read channel: data one cycle after the address is taken
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= `LCB_RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            arready_ff <= !rvalid_ff && !(arready_ff && s_axi_arvalid_in);
            if (arready_ff && s_axi_arvalid_in) begin
                rvalid_ff <= 1'b1;
                rresp_ff <= is_mapped(raddr_idx) ? `LCB_RESP_OKAY : `LCB_RESP_SLVERR;
                case (raddr_idx)
                    `LCB_IDX_MASTER_CONTROL: rdata_ff <= {24'h000000, master_control_ff};
                    `LCB_IDX_MASTER_CONFIG: rdata_ff <= {24'h000000, master_config_ff};
                    `LCB_IDX_POWER: rdata_ff <= {24'h000000, power_ff};
                    `LCB_IDX_BATTERY_MONITOR: rdata_ff <= {24'h000000, battery_monitor_ff};
                    `LCB_IDX_CONTRAST: rdata_ff <= {24'h000000, contrast_ff};
                    `LCB_IDX_TOGGLE_RATE: rdata_ff <= {24'h000000, toggle_rate_ff};
                    `LCB_IDX_SEGMENT_DATA: rdata_ff <= {24'h000000, segment_data_ff};
                    `LCB_IDX_STATUS: rdata_ff <= {24'h000000, pump_ff, regulator_ff,
                        bypass_ff, blink_off_ff, vbat_sync_ff, mode_ff};
                    `LCB_IDX_BLINK_MASK: rdata_ff <= {24'h000000, blink_mask_ff};
                    default: rdata_ff <= 32'h00000000;
                endcase
            end else if (rvalid_ff && s_axi_rready_in) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Battery monitor level and frame strobe come from other logic
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            vbat_meta_ff <= 1'b0;
            vbat_sync_ff <= 1'b0;
            frame_meta_ff <= 1'b0;
            frame_sync_ff <= 1'b0;
            frame_prev_ff <= 1'b0;
        end else begin
            vbat_meta_ff <= vbat_low_in;
            vbat_sync_ff <= vbat_meta_ff;
            frame_meta_ff <= frame_tick_in;
            frame_sync_ff <= frame_meta_ff;
            frame_prev_ff <= frame_sync_ff;
        end
    end

    // Mode decode from the four scattered configuration bits
    always @* begin
        nxt_mode = `LCB_MODE_INVALID;
        nxt_bypass = 1'b1;
        nxt_regulator = 1'b0;
        nxt_pump = 1'b0;
        case ({master_config_ff[`LCB_BIT_CFG_BYPASS], power_ff[`LCB_BIT_PWR_MONITOR],
               battery_monitor_ff[`LCB_BIT_VBM_ENABLE]})
            3'h4: begin
                if (!master_control_ff[`LCB_BIT_CTRL_REGULATOR]) begin
                    nxt_mode = `LCB_MODE_BYPASS;
                end
            end
            3'h7: begin
                if (!master_control_ff[`LCB_BIT_CTRL_REGULATOR]) begin
                    nxt_mode = `LCB_MODE_MINIMUM;
                    nxt_bypass = !vbat_sync_ff;
                    nxt_pump = vbat_sync_ff;
                end
            end
            3'h3: begin
                nxt_mode = `LCB_MODE_CONSTANT;
                nxt_bypass = 1'b0;
                nxt_regulator = !vbat_sync_ff;
                nxt_pump = vbat_sync_ff;
            end
            3'h1: begin
                nxt_mode = `LCB_MODE_FOURTH;
                nxt_bypass = 1'b0;
                nxt_pump = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // Only the low 2*(mux+1) mask bits may blink
    always @* begin
        case (master_control_ff[`LCB_MSB_CTRL_MUX:`LCB_LSB_CTRL_MUX])
            2'h0: nxt_limit_mask = 8'h03;
            2'h1: nxt_limit_mask = 8'h0f;
            2'h2: nxt_limit_mask = 8'h3f;
            default: nxt_limit_mask = 8'hff;
        endcase
        nxt_segment = segment_data_ff & ~(blink_mask_ff & nxt_limit_mask
            & {8{blink_off_ff}});
    end

    // Blink timing: phase flips after toggle_rate+1 frames
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            frame_count_ff <= 8'h00;
            blink_off_ff <= 1'b0;
            segment_ff <= 8'h00;
        end else if (frame_edge) begin
            segment_ff <= nxt_segment;
            if (frame_count_ff >= toggle_rate_ff) begin
                frame_count_ff <= 8'h00;
                blink_off_ff <= !blink_off_ff;
            end else begin
                frame_count_ff <= frame_count_ff + 8'h01;
            end
        end
    end

    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_ff <= `LCB_MODE_INVALID;
            bypass_ff <= 1'b1;
            regulator_ff <= 1'b0;
            pump_ff <= 1'b0;
            high_load_ff <= 1'b0;
            code_ff <= 8'h00;
        end else begin
            mode_ff <= nxt_mode;
            bypass_ff <= nxt_bypass;
            regulator_ff <= nxt_regulator;
            pump_ff <= nxt_pump;
            high_load_ff <= ((nxt_mode == `LCB_MODE_CONSTANT) || (nxt_mode == `LCB_MODE_FOURTH))
                && !master_control_ff[`LCB_BIT_CTRL_REGULATOR];
            code_ff <= (contrast_ff > `LCB_CONTRAST_MAX_CODE) ? `LCB_CONTRAST_MAX_CODE
                : contrast_ff;
        end
    end

endmodule // lcb_contrast_blink

// *** testbench/lcb_cb_asserts.sv ***
`timescale 1ns/10ps
module lcb_cb_asserts (
    input wire ref_clk_in,
    input wire reset_in,
    input wire s_axi_awvalid_in,
    input wire s_axi_awready_out,
    input wire s_axi_wvalid_in,
    input wire s_axi_wready_out,
    input wire [1:0] s_axi_bresp_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire s_axi_arvalid_in,
    input wire s_axi_arready_out,
    input wire s_axi_rvalid_out,
    input wire frame_tick_in,
    input wire [7:0] segment_out,
    input wire [2:0] contrast_mode_out,
    input wire supply_bypass_out,
    input wire regulator_en_out,
    input wire charge_pump_en_out,
    input wire high_load_out,
    input wire [7:0] contrast_code_out
);
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    a_bypass_decode: assert property (
        contrast_mode_out == 3'h1 |->
        supply_bypass_out && !regulator_en_out && !charge_pump_en_out)
        else $error("bypass mode drives regulator or pump");
    a_minimum_decode: assert property (
        contrast_mode_out == 3'h2 |->
        !regulator_en_out && (supply_bypass_out ^ charge_pump_en_out))
        else $error("minimum mode supply choice wrong");
    a_constant_decode: assert property (
        contrast_mode_out == 3'h3 |->
        !supply_bypass_out && (regulator_en_out ^ charge_pump_en_out))
        else $error("constant mode supply choice wrong");
    a_fourth_pump: assert property (
        contrast_mode_out == 3'h4 |-> charge_pump_en_out)
        else $error("fourth mode without charge pump");
    a_high_load: assert property (
        high_load_out |-> contrast_mode_out == 3'h3 || contrast_mode_out == 3'h4)
        else $error("high load outside modes three and four");
    a_code_ceiling: assert property (
        contrast_code_out <= 8'h1e)
        else $error("contrast code above ceiling");
    a_seg_frame: assert property (
        !frame_tick_in [*6] |=> $stable(segment_out))
        else $error("segments changed between frames");
    a_write_answer: assert property (
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
        |-> ##2 s_axi_bvalid_out)
        else $error("write response late");
    a_bresp_hold: assert property (
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped early");
    a_read_answer: assert property (
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read response late");
endmodule // lcb_cb_asserts

// *** testbench/lcb_glass_model.sv ***
`timescale 1ns/10ps
module lcb_glass_model (
    input wire clk_in,
    input wire [7:0] segment_in,
    output reg frame_tick_out,
    output reg [7:0] shown_out,
    output integer frames_out
);
    // Frame strobe two cycles high, then the glass latches what it shows
    initial begin
        frame_tick_out = 1'b0;
        shown_out = 8'h00;
        frames_out = 0;
        forever begin
            repeat (14) @(posedge clk_in);
            frame_tick_out <= 1'b1;
            repeat (2) @(posedge clk_in);
            frame_tick_out <= 1'b0;
            repeat (8) @(posedge clk_in);
            shown_out <= segment_in;
            frames_out <= frames_out + 1;
        end
    end
endmodule // lcb_glass_model

// *** testbench/tb_lcd_contrast_mode_and_blink.sv ***
`timescale 1ns/10ps
`include "lcb_defs.vh"
module tb_lcd_contrast_mode_and_blink;
    reg clk, rst, awv, wv, bre, arv, rre, low;
    reg [11:0] awa, ara;
    reg [31:0] wd;
    wire awr, wr, bv, arr, rv, byp, rg, pmp, hl, tick;
    wire [1:0] br, rr;
    wire [31:0] rd, frames;
    wire [7:0] seg, code, shown;
    wire [2:0] mode;
    integer errors, checks_done;
    lcb_contrast_blink dut (
        .ref_clk_in(clk), .reset_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h1),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .vbat_low_in(low), .frame_tick_in(tick), .segment_out(seg), .contrast_mode_out(mode),
        .supply_bypass_out(byp), .regulator_en_out(rg), .charge_pump_en_out(pmp),
        .high_load_out(hl), .contrast_code_out(code));
    lcb_glass_model glass (.clk_in(clk), .segment_in(seg), .frame_tick_out(tick),
        .shown_out(shown), .frames_out(frames));
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task axw(input [9:0] i, input [7:0] d, input [1:0] er);
        integer n;
        begin
            @(posedge clk);
            awa <= {i, 2'b00};
            wd <= {24'h0, d};
            awv <= 1'b1;
            wv <= 1'b1;
            bre <= 1'b1;
            n = 0;
            while ((awv || wv || !bv) && n < 40) begin
                @(posedge clk);
                n = n + 1;
                if (awr) awv <= 1'b0;
                if (wr) wv <= 1'b0;
            end
            bre <= 1'b0;
            if (n >= 40) errors = errors + 1;
            chk(br, er);
        end
    endtask
    task axr(input [9:0] i, input [7:0] e, input [1:0] er);
        integer n;
        begin
            @(posedge clk);
            ara <= {i, 2'b00};
            arv <= 1'b1;
            rre <= 1'b1;
            n = 0;
            while (rv !== 1'b1 && n < 40) begin
                @(posedge clk);
                n = n + 1;
                if (arr) arv <= 1'b0;
            end
            rre <= 1'b0;
            if (n >= 40) errors = errors + 1;
            chk(rd, {24'h0, e});
            chk(rr, er);
        end
    endtask
    task next_frame;
        integer f, n;
        begin
            f = frames;
            n = 0;
            while (frames == f && n < 200) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 200) errors = errors + 1;
        end
    endtask
    task t_regs;
        begin
            axr(`LCB_IDX_BLINK_MASK, 8'h00, `LCB_RESP_OKAY);
            axr(`LCB_IDX_CONTRAST, 8'h00, `LCB_RESP_OKAY);
            axw(10'h010, 8'h12, `LCB_RESP_SLVERR);
            axr(10'h010, 8'h00, `LCB_RESP_SLVERR);
        end
    endtask
    task t_contrast(input [7:0] c, input [7:0] e);
        begin
            axw(`LCB_IDX_CONTRAST, c, `LCB_RESP_OKAY);
            repeat (2) @(posedge clk);
            chk(code, e);
        end
    endtask
    task mode_case(input [2:0] c, input f, p, v, l, input [2:0] em, input [3:0] m, eo);
        begin
            axw(`LCB_IDX_MASTER_CONTROL, {5'h0, c}, `LCB_RESP_OKAY);
            axw(`LCB_IDX_MASTER_CONFIG, {7'h0, f}, `LCB_RESP_OKAY);
            axw(`LCB_IDX_POWER, {4'h0, p, 3'h0}, `LCB_RESP_OKAY);
            axw(`LCB_IDX_BATTERY_MONITOR, {v, 7'h0}, `LCB_RESP_OKAY);
            low <= l;
            repeat (6) @(posedge clk);
            chk(mode, em);
            chk({byp, rg, pmp, hl} & m, eo);
        end
    endtask
    task blink(input [1:0] mx, input [7:0] r, input [7:0] eoff);
        integer k, on;
        begin
            axw(`LCB_IDX_MASTER_CONTROL, {6'h0, mx}, `LCB_RESP_OKAY);
            axw(`LCB_IDX_SEGMENT_DATA, 8'hff, `LCB_RESP_OKAY);
            axw(`LCB_IDX_BLINK_MASK, 8'h5b, `LCB_RESP_OKAY);
            axw(`LCB_IDX_TOGGLE_RATE, r, `LCB_RESP_OKAY);
            repeat (3) next_frame;
            on = 0;
            for (k = 0; k < 4 * (r + 1); k = k + 1) begin
                next_frame;
                if (shown === 8'hff) on = on + 1;
                else chk(shown, eoff);
            end
            chk(on, 2 * (r + 1));
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errors = errors + 1;
        print_verdict;
    end
    initial begin
        {rst, awv, wv, bre, arv, rre, low} = 7'h40;
        {awa, ara, wd} = 56'h0;
        errors = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_contrast(8'h05, 8'h05);
        t_contrast(8'h1e, 8'h1e);
        t_contrast(8'h1f, 8'h1e);
        mode_case(3'b000, 1, 0, 0, 0, 3'h1, 4'hf, 4'h8);
        mode_case(3'b000, 1, 1, 1, 0, 3'h2, 4'hf, 4'h8);
        mode_case(3'b000, 1, 1, 1, 1, 3'h2, 4'hf, 4'h2);
        mode_case(3'b100, 0, 1, 1, 0, 3'h3, 4'hf, 4'h4);
        mode_case(3'b100, 0, 1, 1, 1, 3'h3, 4'hf, 4'h2);
        mode_case(3'b000, 0, 1, 1, 1, 3'h3, 4'hf, 4'h3);
        mode_case(3'b100, 0, 0, 1, 0, 3'h4, 4'h3, 4'h2);
        mode_case(3'b000, 0, 0, 1, 1, 3'h4, 4'h3, 4'h3);
        mode_case(3'b000, 0, 0, 0, 0, 3'h0, 4'hf, 4'h8);
        blink(2'h3, 8'h00, 8'ha4);
        blink(2'h0, 8'h01, 8'hfc);
        blink(2'h1, 8'h02, 8'hf4);
        blink(2'h2, 8'h00, 8'he4);
        axr(`LCB_IDX_BLINK_MASK, 8'h5b, `LCB_RESP_OKAY);
        print_verdict;
    end
endmodule // tb_lcd_contrast_mode_and_blink
bind lcb_contrast_blink lcb_cb_asserts u_chk (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .frame_tick_in(frame_tick_in),
    .segment_out(segment_out), .contrast_mode_out(contrast_mode_out),
    .supply_bypass_out(supply_bypass_out), .regulator_en_out(regulator_en_out),
    .charge_pump_en_out(charge_pump_en_out), .high_load_out(high_load_out),
    .contrast_code_out(contrast_code_out));
